//--- hw/vdhp_regs.vh
// constants for the video decoder host port: commands, status layout, timing
// assumes inclusion by hw/vdhp_host_port.v only
`ifndef VDHP_REGS_VH
`define VDHP_REGS_VH
// ************************************************************
// command bytes
// ************************************************************
`define VDHP_CMD_STAT0      8'h70
`define VDHP_CMD_STAT1      8'h71
`define VDHP_CMD_VBI_RD     8'h74
`define VDHP_CMD_UC_WR      8'h55
`define VDHP_CMD_UC_RD      8'h76
`define VDHP_CMD_GEN_WR     8'h41
`define VDHP_ADDR_RESUME    8'h7f
// ************************************************************
// status fields and constants
// ************************************************************
`define VDHP_STAT0_DREQ_BIT 4
`define VDHP_STAT0_IRQ_BIT  0
`define VDHP_CHAN_MAP       8'h37
// ************************************************************
// mode a register addresses
// ************************************************************
`define VDHP_A_CMD          2'h0
`define VDHP_A_DATA         2'h1
`define VDHP_A_STATUS       2'h2
`define VDHP_A_ADDR         2'h3
// ************************************************************
// timing and sizes
// ************************************************************
`define VDHP_FIFO_WAITS     2'd2
`define VDHP_PRAM_AW        8
`define VDHP_PRAM_DEPTH     256
`define VDHP_VBI_AW         4
`define VDHP_VBI_DEPTH      16
`define VDHP_WR_BUSY_CYC    3'd4
`endif

//--- hw/vdhp_host_port.v
// host port of the video decoder: fifo-space commands over the parallel mode a handshake
// assumes data_strobe_n, chip select, direction, address and data come from an async host
// and that a board pullup holds the released acknowledge line high
// Contract
// - status zero: command 70 then one byte
// - status zero bit 4 mirrors teletext threshold
// - status zero bit 0 shows interrupt pin
// - status one: command 71, always 37
// - channel map: a,c readers, b writer
// - command 74 streams stored vbi data
// - vbi bytes: one data, two waits
// - host may poll status before reading
// - command 55 streams bytes into program ram
// - ram transfer resets processor, pointer zero
// - write 41 to 7f releases processor
// - command 76 streams program ram out
// - strobe low; acknowledge low when served
// - strobe high; acknowledge released, pulled high
// - interrupt pin open drain or push-pull
// - access during pending write: slave termination
`include "vdhp_regs.vh"
module vdhp_host_port (
   input  wire       ref_clk,
   input  wire       srst,
   input  wire       chip_select_n,
   input  wire       data_strobe_n,
   input  wire       read_not_write,
   input  wire [1:0] host_addr,
   input  wire [7:0] host_data_bus_in,
   output reg  [7:0] host_data_bus_out,
   output wire       host_data_bus_oe,
   output wire       transfer_acknowledge_n_out,
   output wire       transfer_acknowledge_n_oe,
   output reg        slave_terminate,
   input  wire       teletext_threshold,
   input  wire       interrupt_pending,
   input  wire       irq_push_pull,
   output wire       interrupt_request_output_out,
   output wire       interrupt_request_output_oe,
   input  wire       vbi_wr_valid,
   input  wire [7:0] vbi_wr_data,
   output wire       vbi_wr_ready,
   output reg        cpu_reset,
   output reg  [7:0] cpu_program_pointer,
   input  wire [7:0] cpu_fetch_addr,
   output reg  [7:0] cpu_fetch_data
);

// ************************************************************
// overview
// ************************************************************
// one access per strobe: the host holds everything steady while strobe is low,
// so address, data and direction may share the strobe's synchroniser delay.
// fifo-space commands are latched as a mode; data accesses then act on it.
// a write that starts internal work leaves a short busy window; a strobe
// inside it is refused rather than queued, which keeps the datapath single-issue.
// limitation: only one fifo-space stream is open at a time; a new command
// byte closes the previous one.
// the processor hold is a level for the core outside this block.

// ************************************************************
// input synchronisers
// ************************************************************
// two flops per host line; the host has no phase relation to ref_clk
reg  [2:0] sync_a;
reg  [2:0] sync_b;
reg  [1:0] addr_a;
reg  [1:0] addr_b;
reg  [7:0] din_a;
reg  [7:0] din_b;
wire       cs_n   = sync_b[0];
wire       ds_n   = sync_b[1];
wire       rd     = sync_b[2];
always @(posedge ref_clk) begin
   sync_a <= {read_not_write, data_strobe_n, chip_select_n};
   sync_b <= sync_a;
   addr_a <= host_addr;
   addr_b <= addr_a;
   din_a  <= host_data_bus_in;
   din_b  <= din_a;
end

// ************************************************************
// interrupt pin
// ************************************************************
// open drain drives low only when pending; push-pull drives always
assign interrupt_request_output_out = irq_push_pull ? interrupt_pending : 1'b0;
assign interrupt_request_output_oe  = irq_push_pull ? 1'b1 : interrupt_pending;
// status reads only look at the level; nothing here clears the source
wire   interrupt_pin_status = interrupt_pending;

// ************************************************************
// storage
// ************************************************************
// flip-flop storage; the core reads program ram through its own port
reg  [7:0] pram [0:`VDHP_PRAM_DEPTH-1];
reg  [7:0] vbi_mem [0:`VDHP_VBI_DEPTH-1];
reg  [`VDHP_VBI_AW:0] vbi_wp;
reg  [`VDHP_VBI_AW:0] vbi_rp;

// extra pointer bit tells full from empty
wire       vbi_empty = (vbi_wp == vbi_rp);
wire       vbi_full  = (vbi_wp[`VDHP_VBI_AW] != vbi_rp[`VDHP_VBI_AW]) &&
                       (vbi_wp[`VDHP_VBI_AW-1:0] == vbi_rp[`VDHP_VBI_AW-1:0]);
assign vbi_wr_ready = ~vbi_full;
// dma request: threshold flag from the interrupt status block
wire       fifo_a_dma_request = teletext_threshold;

// ************************************************************
// status bytes
// ************************************************************
// two live bits only; the rest read zero so a polling host sees stable values
wire [7:0] status_zero;
wire [7:0] status_one = `VDHP_CHAN_MAP;
genvar     gi;
generate
   for (gi = 0; gi < 8; gi = gi + 1) begin : g_stat0
      if (gi == `VDHP_STAT0_DREQ_BIT) begin : g_dreq
         assign status_zero[gi] = fifo_a_dma_request;
      end else if (gi == `VDHP_STAT0_IRQ_BIT) begin : g_irq
         assign status_zero[gi] = interrupt_pin_status;
      end else begin : g_zero
         assign status_zero[gi] = 1'b0;
      end
   end
endgenerate

// ************************************************************
// handshake state machine
// ************************************************************
// access phases; wait is only used by reads in vbi mode, at any address but the command address
localparam ST_IDLE = 3'd0;
localparam ST_WAIT = 3'd1;
localparam ST_ACK  = 3'd2;
localparam ST_DONE = 3'd3;
localparam ST_TERM = 3'd4;

// latched command mode
localparam MD_NONE = 3'd0;
localparam MD_S0   = 3'd1;
localparam MD_S1   = 3'd2;
localparam MD_VBI  = 3'd3;
localparam MD_UCW  = 3'd4;
localparam MD_UCR  = 3'd5;
localparam MD_GEN  = 3'd6;

reg  [2:0] state;
reg  [2:0] next_state;
reg  [2:0] mode;
reg  [1:0] wait_cnt;
reg  [7:0] gen_addr;
reg  [7:0] pram_ptr;
reg  [2:0] busy_cnt;
reg        ack_drive;
reg        data_drive;
wire       start = (state == ST_IDLE) && !cs_n && !ds_n;
wire       is_cmd = (addr_b == `VDHP_A_CMD);
assign transfer_acknowledge_n_out = 1'b0;
assign transfer_acknowledge_n_oe  = ack_drive;
assign host_data_bus_oe = data_drive;

// strobe seen in idle opens an access; busy turns it into a refusal
always @* begin
   next_state = state;
   case (state)
      ST_IDLE: if (start) begin
         if (busy_cnt != 3'd0)
            next_state = ST_TERM;
         else if (rd && mode == MD_VBI && is_cmd == 1'b0)
            next_state = ST_WAIT;
         else
            next_state = ST_ACK;
      end
      ST_WAIT: if (wait_cnt == `VDHP_FIFO_WAITS - 2'd1) next_state = ST_ACK;
      ST_ACK:  next_state = ST_DONE;
      ST_DONE: if (ds_n) next_state = ST_IDLE;
      ST_TERM: if (ds_n) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
   endcase
end

// ************************************************************
// command decode and data path
// ************************************************************
always @(posedge ref_clk) begin
   // synchronous reset: bus released, processor running, fifo empty
   if (srst) begin
      state               <= ST_IDLE;
      mode                <= MD_NONE;
      wait_cnt            <= 2'd0;
      gen_addr            <= 8'h00;
      pram_ptr            <= 8'h00;
      busy_cnt            <= 3'd0;
      ack_drive           <= 1'b0;
      data_drive          <= 1'b0;
      slave_terminate     <= 1'b0;
      host_data_bus_out   <= 8'h00;
      cpu_reset           <= 1'b0;
      cpu_program_pointer <= 8'h00;
      vbi_wp              <= 5'd0;
      vbi_rp              <= 5'd0;
      cpu_fetch_data      <= 8'h00;
   end else begin
      state <= next_state;
      if (busy_cnt != 3'd0)
         busy_cnt <= busy_cnt - 3'd1;

      // a running core reports where it fetches; a command below forces zero
      if (!cpu_reset)
         cpu_program_pointer <= cpu_fetch_addr;

      // fill side: sliced data arrives from the slicer on this clock
      if (vbi_wr_valid && !vbi_full) begin
         vbi_mem[vbi_wp[`VDHP_VBI_AW-1:0]] <= vbi_wr_data;
         vbi_wp <= vbi_wp + 5'd1;
      end

      if (state == ST_WAIT)
         wait_cnt <= wait_cnt + 2'd1;
      else
         wait_cnt <= 2'd0;

      // refused access: flagged while strobe stays low, no acknowledge
      if (state == ST_TERM)
         slave_terminate <= ~ds_n;
      else
         slave_terminate <= 1'b0;

      // served access: everything below is taken on the edge ack rises
      if (next_state == ST_ACK) begin
         ack_drive <= 1'b1;
         if (!rd && is_cmd) begin
            // pointer restarts at zero on every command byte
            pram_ptr <= 8'h00;
            case (din_b)
               `VDHP_CMD_STAT0:  mode <= MD_S0;
               `VDHP_CMD_STAT1:  mode <= MD_S1;
               `VDHP_CMD_VBI_RD: mode <= MD_VBI;
               `VDHP_CMD_UC_WR: begin
                  mode <= MD_UCW;
                  cpu_reset <= 1'b1;
                  cpu_program_pointer <= 8'h00;
               end
               `VDHP_CMD_UC_RD: begin
                  mode <= MD_UCR;
                  cpu_reset <= 1'b1;
                  cpu_program_pointer <= 8'h00;
               end
               `VDHP_CMD_GEN_WR: mode <= MD_GEN;
               default:          mode <= MD_NONE;
            endcase
         end else if (!rd && addr_b == `VDHP_A_ADDR) begin
            gen_addr <= din_b;
         end else if (!rd) begin
            case (mode)
               MD_UCW: begin
                  pram[pram_ptr] <= din_b;
                  pram_ptr <= pram_ptr + 8'h01;
                  busy_cnt <= `VDHP_WR_BUSY_CYC;
               end
               MD_GEN: begin
                  // processor stays in reset until this write, any data
                  if (gen_addr == `VDHP_ADDR_RESUME)
                     cpu_reset <= 1'b0;
                  busy_cnt <= `VDHP_WR_BUSY_CYC;
               end
               default: busy_cnt <= 3'd0;
            endcase
         end else begin
            data_drive <= 1'b1;
            // direct status address serves polling without a command byte
            if (addr_b == `VDHP_A_STATUS)
               host_data_bus_out <= status_zero;
            else case (mode)
               MD_S0: host_data_bus_out <= status_zero;
               MD_S1: host_data_bus_out <= status_one;
               MD_VBI: begin
                  // empty fifo returns zero rather than stalling the host
                  host_data_bus_out <= vbi_empty ? 8'h00 :
                                       vbi_mem[vbi_rp[`VDHP_VBI_AW-1:0]];
                  if (!vbi_empty)
                     vbi_rp <= vbi_rp + 5'd1;
               end
               MD_UCR: begin
                  host_data_bus_out <= pram[pram_ptr];
                  pram_ptr <= pram_ptr + 8'h01;
               end
               default: host_data_bus_out <= 8'h00;
            endcase
         end
      end

      if (state == ST_DONE && ds_n) begin
         ack_drive  <= 1'b0;
         data_drive <= 1'b0;
      end

      // core fetch port; no arbitration, the core is held during program ram transfers
      cpu_fetch_data <= pram[cpu_fetch_addr];
   end
end
endmodule

//--- sim/vdhp_host_model.sv
// host controller model: one mode a strobe cycle per call of xfer
// assumes host_clk free of ref_clk phase; ack_n and hd already resolved
module vdhp_host_model (
   input  wire logic       host_clk,
   input  wire logic       ack_n,
   input  wire logic [7:0] hd,
   output logic            cs_n,
   output logic            ds_n,
   output logic            rnw,
   output logic      [1:0] addr,
   output logic      [7:0] dout
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cs_n = 1'b1;
      ds_n = 1'b1;
      rnw = 1'b0;
      addr = 2'h0;
      dout = 8'h00;
   end
   // ****
   // strobe cycle
   // ****
   task automatic xfer(input logic r, input logic [1:0] a, input logic [7:0] w,
                       output logic [7:0] d, output logic ok);
      int n;
      @(posedge host_clk);
      cs_n <= 1'b0;
      rnw <= r;
      addr <= a;
      dout <= r ? ~dout : w; // released bus shows a changing pattern
      @(posedge host_clk);
      ds_n <= 1'b0;
      ok = 1'b0;
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge host_clk);
         ok = (ack_n === 1'b0);
      end
      d = hd;
      ds_n <= 1'b1;
      for (n = 0; n < 16 && ack_n !== 1'b1; n++) begin
         @(posedge host_clk);
      end
      cs_n <= 1'b1;
   endtask
endmodule

//--- sim/vdhp_host_port_chk.sv
// checker: host port handshake, interrupt pin, processor hold
// assumes one clock domain; bound onto vdhp_host_port
module vdhp_host_port_chk (
   input wire logic       ref_clk,
   input wire logic       srst,
   input wire logic       data_strobe_n,
   input wire logic       transfer_acknowledge_n_out,
   input wire logic       transfer_acknowledge_n_oe,
   input wire logic       host_data_bus_oe,
   input wire logic       slave_terminate,
   input wire logic       interrupt_pending,
   input wire logic       irq_push_pull,
   input wire logic       interrupt_request_output_out,
   input wire logic       interrupt_request_output_oe,
   input wire logic       cpu_reset,
   input wire logic [7:0] cpu_program_pointer
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   a_ack_after_strobe: assert property ($rose(transfer_acknowledge_n_oe) |-> $past(!data_strobe_n, 2))
      else $error("ack without strobe");
   a_ack_holds: assert property (transfer_acknowledge_n_oe && !data_strobe_n |=> transfer_acknowledge_n_oe)
      else $error("ack dropped early");
   a_ack_release: assert property ($rose(data_strobe_n) |-> ##[1:4] !transfer_acknowledge_n_oe)
      else $error("ack not released");
   a_ack_low: assert property (transfer_acknowledge_n_oe |-> !transfer_acknowledge_n_out)
      else $error("ack driven high");
   a_data_with_ack: assert property (host_data_bus_oe |-> transfer_acknowledge_n_oe)
      else $error("bus driven without ack");
   a_irq_drain: assert property (!irq_push_pull |-> interrupt_request_output_oe == interrupt_pending
      && !interrupt_request_output_out)
      else $error("open drain pin wrong");
   a_irq_push: assert property (irq_push_pull |-> interrupt_request_output_oe
      && interrupt_request_output_out == interrupt_pending)
      else $error("push pull pin wrong");
   a_ptr_zero: assert property (cpu_reset |-> cpu_program_pointer == 8'h00)
      else $error("pointer not zero in reset");
   a_term_no_ack: assert property (slave_terminate |-> !transfer_acknowledge_n_oe)
      else $error("ack during termination");
endmodule
bind vdhp_host_port vdhp_host_port_chk u_chk (.ref_clk, .srst, .data_strobe_n,
   .transfer_acknowledge_n_out, .transfer_acknowledge_n_oe, .host_data_bus_oe, .slave_terminate,
   .interrupt_pending, .irq_push_pull, .interrupt_request_output_out,
   .interrupt_request_output_oe, .cpu_reset, .cpu_program_pointer);

//--- sim/test_video_decoder_host_port.sv
// bench: fifo-space commands through the host model, side inputs driven here
// assumes design, host model and checker compiled before this file
module test_video_decoder_host_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic       ref_clk = 1'b0, srst = 1'b1, host_clk = 1'b0;
   logic       teletext_threshold = 1'b0, interrupt_pending = 1'b0, irq_push_pull = 1'b0;
   logic       vbi_wr_valid = 1'b0;
   logic [7:0] vbi_wr_data = 8'h00, cpu_fetch_addr = 8'h00;
   wire        chip_select_n, data_strobe_n, read_not_write, host_data_bus_oe, slave_terminate;
   wire        transfer_acknowledge_n_out, transfer_acknowledge_n_oe, vbi_wr_ready, cpu_reset;
   wire        interrupt_request_output_out, interrupt_request_output_oe;
   wire  [1:0] host_addr;
   wire  [7:0] host_data_bus_in, host_data_bus_out, cpu_program_pointer, cpu_fetch_data;
   wire        ack_n = transfer_acknowledge_n_oe ? transfer_acknowledge_n_out : 1'b1; // pullup
   wire  [7:0] hd = host_data_bus_oe ? host_data_bus_out : host_data_bus_in;
   int         n_fail = 0, comparisons = 0;
   always #25 ref_clk = ~ref_clk;
   initial begin
      #7;
      forever #200 host_clk = ~host_clk;
   end
   vdhp_host_port u_dut (.ref_clk, .srst, .chip_select_n, .data_strobe_n, .read_not_write,
      .host_addr, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe,
      .transfer_acknowledge_n_out, .transfer_acknowledge_n_oe, .slave_terminate,
      .teletext_threshold, .interrupt_pending, .irq_push_pull, .interrupt_request_output_out,
      .interrupt_request_output_oe, .vbi_wr_valid, .vbi_wr_data, .vbi_wr_ready, .cpu_reset,
      .cpu_program_pointer, .cpu_fetch_addr, .cpu_fetch_data);
   vdhp_host_model u_host (.host_clk, .ack_n, .hd, .cs_n(chip_select_n), .ds_n(data_strobe_n),
      .rnw(read_not_write), .addr(host_addr), .dout(host_data_bus_in));
   // ****
   // shared tasks
   // ****
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xf(input logic r, input logic [1:0] a, input logic [7:0] w,
                     output logic [7:0] d);
      logic ok;
      u_host.xfer(r, a, w, d, ok);
      check({7'h00, ok}, 8'h01);
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_status;
      logic [7:0] d;
      @(posedge ref_clk);
      teletext_threshold <= 1'b1;
      interrupt_pending <= 1'b1;
      irq_push_pull <= 1'b1;
      xf(1'b0, 2'h0, 8'h70, d);
      xf(1'b1, 2'h1, 8'h00, d);
      check(d, 8'h11);
      check({7'h00, interrupt_request_output_out}, 8'h01);
      @(posedge ref_clk);
      teletext_threshold <= 1'b0;
      interrupt_pending <= 1'b0;
      xf(1'b0, 2'h0, 8'h70, d);
      xf(1'b1, 2'h1, 8'h00, d);
      check(d, 8'h00);
      xf(1'b0, 2'h0, 8'h71, d);
      xf(1'b1, 2'h1, 8'h00, d);
      check(d, 8'h37);
   endtask
   task automatic t_vbi;
      logic [7:0] d;
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         vbi_wr_valid <= 1'b1;
         vbi_wr_data <= 8'h80 + i[7:0];
      end
      @(posedge ref_clk);
      vbi_wr_valid <= 1'b0;
      @(negedge ref_clk);
      check({7'h00, vbi_wr_ready}, 8'h00);
      xf(1'b0, 2'h0, 8'h74, d);
      for (int i = 0; i < 16; i++) begin
         xf(1'b1, 2'h1, 8'h00, d);
         check(d, 8'h80 + i[7:0]);
      end
      check({7'h00, vbi_wr_ready}, 8'h01);
   endtask
   task automatic t_ucode;
      logic [7:0] d;
      xf(1'b0, 2'h0, 8'h55, d);
      xf(1'b0, 2'h1, 8'h5a, d);
      xf(1'b0, 2'h1, 8'ha5, d);
      check({7'h00, cpu_reset}, 8'h01);
      check(cpu_program_pointer, 8'h00);
      xf(1'b0, 2'h0, 8'h41, d);
      xf(1'b0, 2'h3, 8'h7f, d);
      xf(1'b0, 2'h1, 8'hc3, d);
      check({7'h00, cpu_reset}, 8'h00);
      @(posedge ref_clk);
      cpu_fetch_addr <= 8'h01;
      repeat (2) @(posedge ref_clk);
      #1 check(cpu_fetch_data, 8'ha5);
      xf(1'b0, 2'h0, 8'h76, d);
      xf(1'b1, 2'h1, 8'h00, d);
      check(d, 8'h5a);
      xf(1'b1, 2'h1, 8'h00, d);
      check(d, 8'ha5);
      check({7'h00, cpu_reset}, 8'h01);
   endtask
   task automatic t_irq;
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         irq_push_pull <= i[1];
         interrupt_pending <= i[0];
         @(negedge ref_clk);
         check({6'h00, interrupt_request_output_oe, interrupt_request_output_out},
               i[1] ? {6'h00, 1'b1, i[0]} : {6'h00, i[0], 1'b0});
      end
   endtask
   initial begin
      #1000000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      @(negedge ref_clk);
      check({7'h00, cpu_reset}, 8'h00); // reset leaves the processor running
      t_status();
      t_vbi();
      t_ucode();
      t_irq();
      tally_and_finish();
   end
endmodule
